// ### src/fhrs_pkg.sv
// Constants shared by the floppy host rate, status and data register block.
// Assumes one 250 MHz clock and a host I/O bus that is synchronous to it.
// How it works
// - Rate-select bits 2 to 4 pick the write precompensation shift code.
// - Precompensation starts at track 0 unless a configure command moves it.
// - Rate-select bit 6 enters low power; software reset or status/data access leaves.
// - Rate-select bit 7 gives a software reset like the drive control one, self-clearing.
// - Every rate-select write is copied whole into a readable shadow byte.
// - Shift steps are 41.67 ns below 2 Mbps, 20.8 ns at 2 Mbps; one default code.
// - Default shift is 20.8 ns at 2M, 41.67 ns at 1M, 125 ns otherwise.
// - Drive type and rate code choose the data rate; type 10 code 01 is 2M.
// - Density output is high for the 1M and 500K codes; rate value equals code.
// - Drive density pins are mapped from rate bits and density per drive kind.
// - Status at 3F4 is read-only, always readable, without side effects on transfers.
// - Status bits 0 and 1 show each drive seeking.
// - Status bit 4 shows a command in progress.
// - Status bit 5 is set during polled execution.
// - Status bit 6 gives direction: one is host read, zero host write.
// - Status bit 7 permits a data byte; no data access while it is clear.
// - Data register at 3F5 carries all bytes both ways.
// - After reset the data FIFO is disabled; configure may enable it.
// - Command bytes use the handshake; execution entry empties stale bytes.
// - Overrun or underrun ends the command; host meets the service deadline.
// - Rate-select is write-only at 3F4, resets to 02H, untouched by software reset.
// - The data rate follows whichever rate register was written last.
package fhrs_pkg;
  localparam logic [15:0] FHRS_ADDR_STATUS = 16'h03F4;
  localparam logic [15:0] FHRS_ADDR_DATA   = 16'h03F5;
  localparam logic [7:0]  FHRS_RATE_RST    = 8'h02;
  localparam logic [7:0]  FHRS_FILL_BYTE   = 8'h00;
  localparam logic [7:0]  FHRS_TRACK_RST   = 8'h00;
  // Field positions inside the rate-select byte.
  localparam int FHRS_RS_RATE_LO = 0;
  localparam int FHRS_RS_PREC_LO = 2;
  localparam int FHRS_RS_LOWPWR  = 6;
  localparam int FHRS_RS_SWRST   = 7;
  // Precompensation code that selects the rate-dependent default; reset value 02H holds it.
  localparam logic [2:0] FHRS_PREC_DEFAULT = 3'h0;
  // Code for no shift; the six others count steps, so 250 ns tops the range.
  localparam logic [2:0] FHRS_PREC_ZERO    = 3'h7;
  // Default shift in steps: 2M and 1M use one step, slower rates three.
  localparam logic [2:0] FHRS_PREC_DEF_FAST = 3'h1;
  localparam logic [2:0] FHRS_PREC_DEF_SLOW = 3'h3;
  // Rate codes and drive types.
  localparam logic [1:0] FHRS_RATE_500K = 2'h0;
  localparam logic [1:0] FHRS_RATE_300K = 2'h1;
  localparam logic [1:0] FHRS_RATE_250K = 2'h2;
  localparam logic [1:0] FHRS_RATE_1M   = 2'h3;
  localparam logic [1:0] FHRS_DT_STD    = 2'h0;
  localparam logic [1:0] FHRS_DT_3MODE  = 2'h1;
  localparam logic [1:0] FHRS_DT_TAPE   = 2'h2;
  localparam logic [1:0] FHRS_DT_ALT    = 2'h3;
endpackage : fhrs_pkg

// ### src/fhrs_strm_if.sv
// Valid/ready byte stream between the register block and its buffers.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface fhrs_strm_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fhrs_strm_if
`default_nettype wire

// ### src/fhrs_buf.sv
// Small in-order buffer; the head entry is a register that drives the output.
// Assumes a synchronous active-high reset and a flush that drops all entries.
`timescale 1ns/10ps
`default_nettype none
module fhrs_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  input  wire logic   flush_i,
  // Streams.
  fhrs_strm_if.snk    in_s,
  fhrs_strm_if.src    out_s
);
  localparam int CW = $clog2(DEPTH + 1);

  // The shift structure needs at least two entries to keep full throughput.
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
    $error("fhrs_buf needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] entry_r [DEPTH];
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             valid_r;
  logic             ready_r;
  wire              push = in_s.valid & ready_r;
  wire              pop  = out_s.ready & valid_r;

  assign cnt_nxt     = flush_i ? '0 : CW'(cnt_r + CW'(push) - CW'(pop));
  assign in_s.ready  = ready_r;
  assign out_s.valid = valid_r;
  assign out_s.data  = entry_r[0];

  // Count and flags are registered so that ready and valid come from flops.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_r   <= '0;
      valid_r <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      cnt_r   <= cnt_nxt;
      valid_r <= cnt_nxt != '0;
      ready_r <= cnt_nxt != CW'(DEPTH);
    end
  end

  // Each entry shifts toward the head on a pop and takes new data at the tail.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire [WIDTH-1:0] above = (i == DEPTH - 1) ? entry_r[i] : entry_r[(i + 1) % DEPTH];
    wire             tail  = pop ? (CW'(i + 1) == cnt_r) : (CW'(i) == cnt_r);
    always_ff @(posedge ref_clk_i) begin
      if (push && tail) begin
        entry_r[i] <= in_s.data;
      end else if (pop) begin
        entry_r[i] <= above;
      end
    end
  end
endmodule : fhrs_buf
`default_nettype wire

// ### src/fhrs_top.sv
// Host-facing rate-select, status and data registers of the floppy controller.
// Assumes the I/O bus strobes are one-cycle pulses on ref_clk_i and the command
// engine sits outside, on the same clock, behind the core_* ports.
`timescale 1ns/10ps
`default_nettype none
module fhrs_top
  import fhrs_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Host I/O bus.
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  // Other rate sources and configuration.
  input  wire logic        rate_config_write_i,
  input  wire logic [1:0]  rate_config_value_i,
  input  wire logic        drive_output_control_reset_i,
  input  wire logic [1:0]  drive_type_i,
  input  wire logic [1:0]  drive_kind_i,
  input  wire logic        cfg_fifo_wr_i,
  input  wire logic        cfg_fifo_en_i,
  input  wire logic        cfg_track_wr_i,
  input  wire logic [7:0]  cfg_track_i,
  input  wire logic [7:0]  cur_track_i,
  // Command engine state.
  input  wire logic        drive0_seeking_i,
  input  wire logic        drive1_seeking_i,
  input  wire logic        core_cmd_busy_i,
  input  wire logic        core_exec_i,
  input  wire logic        core_polled_i,
  input  wire logic        transfer_direction_i,
  input  wire logic        core_sector_end_i,
  // Bytes from the host to the engine.
  output logic             core_wr_valid_o,
  output logic      [7:0]  core_wr_data_o,
  input  wire logic        core_wr_ready_i,
  // Bytes from the engine to the host.
  input  wire logic        core_rd_valid_i,
  input  wire logic [7:0]  core_rd_data_i,
  output logic             core_rd_ready_o,
  // Drive and engine controls.
  output logic [7:0]       rate_shadow_copy_o,
  output logic [1:0]       rate_code_o,
  output logic             density_select_out_o,
  output logic             drive_density_pin0_o,
  output logic             drive_density_pin1_o,
  output logic [2:0]       write_shift_steps_o,
  output logic             write_shift_fine_o,
  output logic             write_shift_on_o,
  output logic             low_power_o,
  output logic             soft_reset_o,
  output logic             xfer_abort_o,
  output logic             fill_sector_o
);
  // Register state.
  logic [7:0] rate_sel_r;
  logic [1:0] rate_r;
  logic [7:0] start_track_r;
  logic       fifo_en_r;
  logic       exec_d_r;

  // Bus decode.
  wire hit_status = io_addr_i == FHRS_ADDR_STATUS;
  wire hit_data   = io_addr_i == FHRS_ADDR_DATA;
  wire rs_wr      = io_wr_i & hit_status;
  wire st_rd      = io_rd_i & hit_status;
  wire dat_wr     = io_wr_i & hit_data;
  wire dat_rd     = io_rd_i & hit_data;
  wire sw_rst     = (rs_wr & io_wdata_i[FHRS_RS_SWRST]) | drive_output_control_reset_i;
  wire exec_rise  = core_exec_i & ~exec_d_r;

  // Data path buffers, one per direction.
  fhrs_strm_if #(.WIDTH(8)) h2c_in  ();
  fhrs_strm_if #(.WIDTH(8)) h2c_out ();
  fhrs_strm_if #(.WIDTH(8)) c2h_in  ();
  fhrs_strm_if #(.WIDTH(8)) c2h_out ();
  wire buf_flush = sw_rst | exec_rise;

  fhrs_buf #(.WIDTH(8), .DEPTH(2)) u_h2c (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .flush_i   (buf_flush),
    .in_s      (h2c_in),
    .out_s     (h2c_out)
  );
  fhrs_buf #(.WIDTH(8), .DEPTH(2)) u_c2h (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .flush_i   (buf_flush),
    .in_s      (c2h_in),
    .out_s     (c2h_out)
  );

  // Transfer permit: with the FIFO off only one host-to-engine byte is in flight at a time
  // (engine-to-host bytes still fill both entries), keeping the byte-by-byte handshake for command parameters.
  wire fifo_on   = fifo_en_r & core_exec_i;
  wire permit_wr = fifo_on ? h2c_in.ready : ~h2c_out.valid;
  wire permit_rd = c2h_out.valid;
  wire permit    = transfer_direction_i ? permit_rd : permit_wr;
  wire [7:0] status_byte = {permit, transfer_direction_i,
                            core_polled_i & core_exec_i,
                            core_cmd_busy_i, 2'h0,
                            drive1_seeking_i, drive0_seeking_i};

  // Bytes move only when permitted, so a stray access cannot corrupt a buffer.
  assign h2c_in.valid  = dat_wr & permit & ~transfer_direction_i;
  assign h2c_in.data   = io_wdata_i;
  assign h2c_out.ready = core_wr_ready_i;
  assign c2h_in.valid  = core_rd_valid_i;
  assign c2h_in.data   = core_rd_data_i;
  assign c2h_out.ready = dat_rd & permit & transfer_direction_i;
  assign core_wr_valid_o = h2c_out.valid;
  assign core_wr_data_o  = h2c_out.data;
  assign core_rd_ready_o = c2h_in.ready;

  // Transfer errors during execution; the write one also starts sector fill.
  wire underrun = core_exec_i & ~transfer_direction_i & core_wr_ready_i & ~h2c_out.valid;
  wire overrun  = core_exec_i & transfer_direction_i & core_rd_valid_i & ~c2h_in.ready;

  // Rate and precompensation decode.
  wire       is_2m      = (drive_type_i == FHRS_DT_TAPE) && (rate_r == FHRS_RATE_300K);
  wire       is_1m      = rate_r == FHRS_RATE_1M;
  wire       density_select_out     = (rate_r == FHRS_RATE_1M) || (rate_r == FHRS_RATE_500K);
  wire [2:0] prec_code  = rate_sel_r[FHRS_RS_PREC_LO +: 3];
  wire [2:0] prec_def   = (is_2m || is_1m) ? FHRS_PREC_DEF_FAST : FHRS_PREC_DEF_SLOW;
  wire       prec_none  = prec_code == FHRS_PREC_ZERO;
  wire [2:0] prec_steps = (prec_code == FHRS_PREC_DEFAULT) ? prec_def :
                          (prec_none ? 3'h0 : prec_code);
  logic den1_nxt;
  logic den0_nxt;

  // Drive density pin map by drive kind.
  always_comb begin
    unique case (drive_kind_i)
      FHRS_DT_STD: begin
        den1_nxt = rate_r[0];
        den0_nxt = density_select_out;
      end
      FHRS_DT_TAPE: begin
        den1_nxt = rate_r[0];
        den0_nxt = rate_r[1];
      end
      FHRS_DT_3MODE: begin
        den1_nxt = rate_r[0];
        den0_nxt = ~density_select_out;
      end
      FHRS_DT_ALT: begin
        den1_nxt = rate_r[1];
        den0_nxt = rate_r[0];
      end
    endcase
  end

  // Rate-select register survives a software reset; only hardware reset loads 02H.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rate_sel_r         <= FHRS_RATE_RST;
      rate_shadow_copy_o <= FHRS_RATE_RST;
    end else if (rs_wr) begin
      rate_sel_r         <= {1'b0, io_wdata_i[6:0]};
      rate_shadow_copy_o <= io_wdata_i;
    end
  end

  // Last writer wins between rate-select and the configuration rate register.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rate_r <= FHRS_RATE_RST[1:0];
    end else if (rs_wr) begin
      rate_r <= io_wdata_i[FHRS_RS_RATE_LO +: 2];
    end else if (rate_config_write_i) begin
      rate_r <= rate_config_value_i;
    end
  end

  // Configure command settings; the FIFO returns to disabled on any reset.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sw_rst) begin
      fifo_en_r     <= 1'b0;
      start_track_r <= FHRS_TRACK_RST;
    end else begin
      if (cfg_fifo_wr_i) fifo_en_r <= cfg_fifo_en_i;
      if (cfg_track_wr_i) start_track_r <= cfg_track_i;
    end
  end

  // Low power: a new entry in the same cycle as a wake access wins.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      low_power_o <= 1'b0;
    end else if (rs_wr && io_wdata_i[FHRS_RS_LOWPWR] && !io_wdata_i[FHRS_RS_SWRST]) begin
      low_power_o <= 1'b1;
    end else if (sw_rst || st_rd || dat_rd || dat_wr) begin
      low_power_o <= 1'b0;
    end
  end

  // Read data: status reads have no effect on the buffers.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      io_rdata_o <= 8'h00;
    end else if (st_rd) begin
      io_rdata_o <= status_byte;
    end else if (dat_rd) begin
      io_rdata_o <= c2h_out.ready ? c2h_out.data : 8'h00;
    end
  end

  // Pulses, error handling and drive-facing outputs.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      soft_reset_o         <= 1'b0;
      xfer_abort_o         <= 1'b0;
      fill_sector_o        <= 1'b0;
      exec_d_r             <= 1'b0;
      rate_code_o          <= FHRS_RATE_RST[1:0];
      density_select_out_o <= 1'b0;
      drive_density_pin0_o <= 1'b0;
      drive_density_pin1_o <= 1'b0;
      write_shift_steps_o  <= 3'h0;
      write_shift_fine_o   <= 1'b0;
      write_shift_on_o     <= 1'b0;
    end else begin
      soft_reset_o         <= sw_rst;
      xfer_abort_o         <= underrun | overrun;
      exec_d_r             <= core_exec_i;
      rate_code_o          <= rate_r;
      density_select_out_o <= density_select_out;
      drive_density_pin0_o <= den0_nxt;
      drive_density_pin1_o <= den1_nxt;
      write_shift_steps_o  <= prec_steps;
      write_shift_fine_o   <= is_2m;
      write_shift_on_o     <= cur_track_i >= start_track_r;
      if (underrun) begin
        fill_sector_o <= 1'b1;
      end else if (core_sector_end_i || sw_rst) begin
        fill_sector_o <= 1'b0;
      end
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rs_write_swrst;
    rs_wr && io_wdata_i[FHRS_RS_SWRST];
  endsequence
  sequence s_pulse_then_clear;
    soft_reset_o ##1 (!soft_reset_o || $past(sw_rst));
  endsequence

  chk_swrst_self_clear: assert property (s_rs_write_swrst |=> s_pulse_then_clear)
    else $error("software reset did not pulse and clear");
  chk_shadow_copy_all: assert property (rs_wr |=> rate_shadow_copy_o == $past(io_wdata_i))
    else $error("shadow copy differs from written byte");
  chk_lowpwr_wake_access: assert property ((st_rd || dat_rd) && !rs_wr |=> !low_power_o)
    else $error("low power not left on access");
  chk_status_read_permit: assert property (st_rd |=> io_rdata_o[7] == $past(permit))
    else $error("status permit bit wrong");
  chk_status_seek_bits: assert property (st_rd |=>
      io_rdata_o[1:0] == $past({drive1_seeking_i, drive0_seeking_i}) && io_rdata_o[3:2] == 2'h0)
    else $error("status seek bits wrong");
  chk_density_rate_map: assert property (##1 density_select_out_o ==
      ($past(rate_r) == FHRS_RATE_1M || $past(rate_r) == FHRS_RATE_500K))
    else $error("density select does not follow rate");
  chk_rate_last_writer: assert property (!rs_wr && rate_config_write_i |=>
      rate_r == $past(rate_config_value_i))
    else $error("rate config write not taken");
  chk_swrst_keeps_rate: assert property (drive_output_control_reset_i && !rs_wr |=> $stable(rate_sel_r))
    else $error("software reset changed rate select");
  chk_exec_flush_bufs: assert property (exec_rise |=> !core_wr_valid_o && !c2h_out.valid)
    else $error("buffers not emptied on execution entry");
  chk_underrun_aborts: assert property (underrun |=> xfer_abort_o && fill_sector_o)
    else $error("underrun did not abort and fill");
  chk_default_write_shift_code: assert property (prec_code == FHRS_PREC_DEFAULT && !is_2m && !is_1m
      |=> write_shift_steps_o == 3'h3)
    else $error("slow default shift is not three steps");

  // Entry, status-field, buffer-mode, error, shift-code and pin-map checks.
  chk_lowpwr_entry: assert property (rs_wr && io_wdata_i[FHRS_RS_LOWPWR]
      && !io_wdata_i[FHRS_RS_SWRST] |=> low_power_o)
    else $error("low power not entered");
  chk_status_mode_bits: assert property (st_rd |=> io_rdata_o[6:4] ==
      $past({transfer_direction_i, core_polled_i & core_exec_i, core_cmd_busy_i}))
    else $error("status direction, polled or busy bit wrong");
  chk_fifo_off_reset: assert property (sw_rst |=> !fifo_en_r)
    else $error("buffer mode survived a software reset");
  chk_overrun_aborts: assert property (overrun |=> xfer_abort_o)
    else $error("overrun did not abort");
  chk_zero_shift_code: assert property (prec_code == FHRS_PREC_ZERO
      |=> write_shift_steps_o == 3'h0)
    else $error("zero shift code gave a shift");
  chk_std_pin_map: assert property (drive_kind_i == FHRS_DT_STD
      |=> drive_density_pin0_o == $past(density_select_out))
    else $error("standard pin map does not carry density");
endmodule : fhrs_top
`default_nettype wire

// ### bench/fhrs_engine_model.sv
// Behavioural command engine standing behind the core_* ports of the block.
// Assumes the bench sets stall_r and calls push from its own sequence.
`timescale 1ns/10ps
`default_nettype none
module fhrs_engine_model (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Host bytes toward the engine.
  input  wire logic       wr_valid_i,
  input  wire logic [7:0] wr_data_i,
  output logic            wr_ready_o,
  // Engine bytes toward the host.
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o,
  input  wire logic       rd_ready_i
);
  logic       stall_r;
  logic [7:0] got_q[$];
  // A stalled engine holds ready low, so the block must keep its word.
  assign wr_ready_o = !stall_r;
  // Idle lines at time zero.
  initial begin
    stall_r    = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o  = 8'h00;
  end
  // Accepted host bytes are queued so the bench can check their order.
  always @(posedge ref_clk_i) begin
    if (!rst_i && wr_valid_i && wr_ready_o) got_q.push_back(wr_data_i);
  end
  // Offers a byte until taken or 50 more cycles pass; force_one pushes for one cycle even when refused.
  task automatic push(input logic [7:0] b, input logic force_one);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    rd_valid_o = 1'b1;
    rd_data_o  = b;
    @(posedge ref_clk_i);
    while (!rd_ready_i && !force_one && n < 50) begin
      @(posedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    rd_valid_o = 1'b0;
    rd_data_o  = ~b;  // A released line must not look like the last byte.
  endtask : push
endmodule : fhrs_engine_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the floppy host rate, status and data register block.
// Assumes the engine model stands behind the core_* ports on the same clock.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import fhrs_pkg::*;
;
  logic        ref_clk_i, rst_i, io_rd_i, io_wr_i, rate_config_write_i, cfg_fifo_wr_i;
  logic        drive_output_control_reset_i, cfg_fifo_en_i, cfg_track_wr_i, core_exec_i;
  logic        drive0_seeking_i, drive1_seeking_i, core_cmd_busy_i, core_polled_i;
  logic        transfer_direction_i, core_sector_end_i, core_wr_ready_i, core_rd_valid_i;
  logic        core_wr_valid_o, core_rd_ready_o, density_select_out_o, drive_density_pin0_o;
  logic        drive_density_pin1_o, write_shift_fine_o, write_shift_on_o, low_power_o;
  logic        soft_reset_o, xfer_abort_o, fill_sector_o, seen;
  logic [15:0] io_addr_i;
  logic [7:0]  io_wdata_i, io_rdata_o, cfg_track_i, cur_track_i, core_wr_data_o;
  logic [7:0]  core_rd_data_i, rate_shadow_copy_o;
  logic [1:0]  rate_config_value_i, drive_type_i, drive_kind_i, rate_code_o;
  logic [2:0]  write_shift_steps_o;
  int          bad_count, checks_done, cycles;

  fhrs_top DUT (
    .ref_clk_i, .rst_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o,
    .rate_config_write_i, .rate_config_value_i, .drive_output_control_reset_i, .drive_type_i,
    .drive_kind_i, .cfg_fifo_wr_i, .cfg_fifo_en_i, .cfg_track_wr_i, .cfg_track_i, .cur_track_i,
    .drive0_seeking_i, .drive1_seeking_i, .core_cmd_busy_i, .core_exec_i, .core_polled_i,
    .transfer_direction_i, .core_sector_end_i, .core_wr_valid_o, .core_wr_data_o,
    .core_wr_ready_i, .core_rd_valid_i, .core_rd_data_i, .core_rd_ready_o, .rate_shadow_copy_o,
    .rate_code_o, .density_select_out_o, .drive_density_pin0_o, .drive_density_pin1_o,
    .write_shift_steps_o, .write_shift_fine_o, .write_shift_on_o, .low_power_o, .soft_reset_o,
    .xfer_abort_o, .fill_sector_o
  );
  fhrs_engine_model eng (
    .ref_clk_i, .rst_i, .wr_valid_i(core_wr_valid_o), .wr_data_i(core_wr_data_o),
    .wr_ready_o(core_wr_ready_i), .rd_valid_o(core_rd_valid_i), .rd_data_o(core_rd_data_i),
    .rd_ready_i(core_rd_ready_o)
  );

  // Clock at 250 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // A hang is cut short long after the sequence should have ended.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick
  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask : pulse
  // One bus access: strobe raised after a falling edge, taken at the next rising edge.
  task automatic io(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(negedge ref_clk_i);
    io_addr_i  = a;
    io_wdata_i = d;
    io_wr_i    = wr;
    io_rd_i    = ~wr;
    @(negedge ref_clk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask : io
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    io(a, 1'b0, 8'h00);
    chk_byte(io_rdata_o, exp);
  endtask : rd
  // Writes one rate-select byte under a drive type and pin mapping, then checks decodes.
  task automatic rate_case(input int dt, input int dk, input int rc);
    logic [2:0] pc, st;
    logic       den, fast, p1, p0;
    pc = 3'((dt * 16 + dk * 4 + rc) % 8);
    drive_type_i = 2'(dt);
    drive_kind_i = 2'(dk);
    io(FHRS_ADDR_STATUS, 1'b1, {3'h0, pc, 2'(rc)});
    tick(3);
    den  = (rc == 3 || rc == 0);
    fast = (dt == 2 && rc == 1);
    st   = (pc == FHRS_PREC_ZERO) ? 3'h0 : (pc != FHRS_PREC_DEFAULT) ? pc :
           ((fast || rc == 3) ? 3'h1 : 3'h3);
    p1   = (dk == 3) ? rc[1] : rc[0];
    p0   = (dk == 0) ? den : (dk == 1) ? ~den : (dk == 2) ? rc[1] : rc[0];
    chk_byte(rate_shadow_copy_o, {3'h0, pc, 2'(rc)});
    chk_byte({6'h00, rate_code_o}, 8'(rc));
    chk_bit(density_select_out_o, den);
    chk_byte({6'h00, drive_density_pin1_o, drive_density_pin0_o}, {6'h00, p1, p0});
    chk_byte({4'h0, write_shift_fine_o, write_shift_steps_o}, {4'h0, fast, st});
  endtask : rate_case

  // Main sequence; every input has a value at time zero.
  initial begin
    {io_rd_i, io_wr_i, rate_config_write_i, drive_output_control_reset_i, cfg_fifo_wr_i} = '0;
    {cfg_fifo_en_i, cfg_track_wr_i, drive0_seeking_i, drive1_seeking_i, core_cmd_busy_i} = '0;
    {core_exec_i, core_polled_i, transfer_direction_i, core_sector_end_i} = '0;
    {io_addr_i, io_wdata_i, cfg_track_i, cur_track_i, rate_config_value_i} = '0;
    {drive_type_i, drive_kind_i} = '0;
    rst_i = 1'b1;
    tick(8);
    rst_i = 1'b0;
    chk_byte(rate_shadow_copy_o, FHRS_RATE_RST);
    tick(2);
    chk_byte({5'h00, write_shift_steps_o}, 8'h03);
    rd(FHRS_ADDR_STATUS, 8'h80);
    for (int dt = 0; dt < 3; dt++) begin
      for (int dk = 0; dk < 4; dk++) begin
        for (int rc = 0; rc < 4; rc++) begin
          rate_case(dt, dk, rc);
        end
      end
    end
    {drive_type_i, drive_kind_i} = '0;
    rate_config_value_i = 2'h1;
    pulse(rate_config_write_i);
    tick(2);
    chk_byte({6'h00, rate_code_o}, 8'h01);
    io(FHRS_ADDR_STATUS, 1'b1, 8'h1E);
    tick(2);
    chk_byte({6'h00, rate_code_o}, 8'h02);
    // Start track for precompensation, and its return to track 0 on soft reset.
    cfg_track_i = 8'h05;
    cur_track_i = 8'h04;
    pulse(cfg_track_wr_i);
    tick(2);
    chk_bit(write_shift_on_o, 1'b0);
    cur_track_i = 8'h05;
    tick(2);
    chk_bit(write_shift_on_o, 1'b1);
    cur_track_i = 8'h04;
    pulse(drive_output_control_reset_i);
    chk_bit(soft_reset_o, 1'b1);
    tick(2);
    chk_bit(write_shift_on_o, 1'b1);
    // Low power is left by a status read and by a self-clearing soft reset.
    io(FHRS_ADDR_STATUS, 1'b1, 8'h42);
    chk_bit(low_power_o, 1'b1);
    rd(FHRS_ADDR_STATUS, 8'h80);
    chk_bit(low_power_o, 1'b0);
    io(FHRS_ADDR_STATUS, 1'b1, 8'h42);
    io(FHRS_ADDR_STATUS, 1'b1, 8'h82);
    chk_byte({6'h00, soft_reset_o, low_power_o}, 8'h02);
    tick(1);
    chk_byte({6'h00, soft_reset_o, rate_code_o[1]}, 8'h01);
    // Status fields follow the engine state.
    drive0_seeking_i = 1'b1;
    core_cmd_busy_i  = 1'b1;
    core_polled_i    = 1'b1;
    rd(FHRS_ADDR_STATUS, 8'h91);
    drive0_seeking_i     = 1'b0;
    drive1_seeking_i     = 1'b1;
    core_exec_i          = 1'b1;
    rd(FHRS_ADDR_STATUS, 8'hB2);
    transfer_direction_i = 1'b1;
    rd(FHRS_ADDR_STATUS, 8'h72);
    rd(FHRS_ADDR_DATA, 8'h00);
    // Engine bytes reach the host in order; a full buffer refuses and aborts.
    eng.push(8'hA5, 1'b0);
    eng.push(8'h3C, 1'b0);
    tick(1);
    chk_bit(core_rd_ready_o, 1'b0);
    rd(FHRS_ADDR_STATUS, 8'hF2);
    rd(FHRS_ADDR_DATA, 8'hA5);
    rd(FHRS_ADDR_STATUS, 8'hF2);
    rd(FHRS_ADDR_DATA, 8'h3C);
    rd(FHRS_ADDR_STATUS, 8'h72);
    eng.push(8'h11, 1'b0);
    eng.push(8'h22, 1'b0);
    eng.push(8'h33, 1'b1);
    seen = xfer_abort_o;
    tick(1);
    chk_bit(seen | xfer_abort_o, 1'b1);
    core_exec_i = 1'b0;
    tick(1);
    core_exec_i = 1'b1;
    tick(2);
    rd(FHRS_ADDR_STATUS, 8'h72);
    // Host bytes with the buffer disabled: one word at a time while stalled.
    {transfer_direction_i, core_exec_i, drive1_seeking_i} = '0;
    eng.stall_r = 1'b1;
    rd(FHRS_ADDR_STATUS, 8'h90);
    io(FHRS_ADDR_DATA, 1'b1, 8'h5A);
    chk_byte({core_wr_valid_o, 7'h00} | 8'(core_wr_data_o == 8'h5A), 8'h81);
    rd(FHRS_ADDR_STATUS, 8'h10);
    io(FHRS_ADDR_DATA, 1'b1, 8'hC3);
    eng.stall_r = 1'b0;
    tick(3);
    chk_byte(8'(eng.got_q.size()), 8'h01);
    chk_byte(eng.got_q.pop_front(), 8'h5A);
    // With the buffer enabled in execution, two words fit before refusal.
    cfg_fifo_en_i = 1'b1;
    pulse(cfg_fifo_wr_i);
    core_exec_i = 1'b1;
    eng.stall_r = 1'b1;
    tick(2);
    rd(FHRS_ADDR_STATUS, 8'hB0);
    io(FHRS_ADDR_DATA, 1'b1, 8'h01);
    rd(FHRS_ADDR_STATUS, 8'hB0);
    io(FHRS_ADDR_DATA, 1'b1, 8'h02);
    rd(FHRS_ADDR_STATUS, 8'h30);
    eng.stall_r = 1'b0;
    tick(4);
    chk_byte(8'(eng.got_q.size()), 8'h02);
    chk_byte(eng.got_q.pop_front(), 8'h01);
    chk_bit(fill_sector_o, 1'b1);
    core_exec_i = 1'b0;
    pulse(core_sector_end_i);
    chk_bit(fill_sector_o, 1'b0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
